// file: hdl/clkin_pkg.sv
// Register map, field layout and encodings for the input clock configuration block
package clkin_pkg;
	// Printed offsets are not multiples of four: they are register indices
	localparam logic [11:0] IDX_XTAL_INPUT_CONFIG    = 12'h300;
	localparam logic [11:0] IDX_XTAL_AMP_CONTROL     = 12'h301;
	localparam logic [11:0] IDX_XTAL_LOAD_CAPS       = 12'h302;
	localparam logic [11:0] IDX_CLOCK_INPUT_ONE      = 12'h303;
	localparam logic [11:0] IDX_CLOCK_INPUT_TWO      = 12'h304;
	localparam logic [11:0] IDX_CLOCK_INPUT_THREE    = 12'h305;
	localparam logic [11:0] IDX_MASTER_CONFIG_TWO    = 12'h306;
	localparam logic [11:0] IDX_MONITOR_STATUS       = 12'h307;
	localparam int          ADDR_W                   = 14;
	// Field positions inside each input configuration byte, and last the doubler bit of master config two
	localparam int          LOCK_EDGE_BIT            = 6;
	localparam int          MON_DIS_BIT              = 5;
	localparam int          VALWIN_LSB               = 2;
	localparam int          PREDIV_LSB               = 0;
	localparam int          DOUBLER_BIT              = 0;
	// Reset values
	localparam logic [7:0]  RST_CONFIG               = 8'h00;
	// Validation window lengths in input cycles
	localparam int          WIN_MAX                  = 1024;
	localparam int          WIN_W                    = 11;
	// Missing-edge timeout measured in aclk cycles
	localparam int          EDGE_TIMEOUT             = 64;
	localparam int          TMO_W                    = 7;
	// AXI responses, then the number of monitored inputs
	localparam logic [1:0]  RESP_OKAY                = 2'b00;
	localparam logic [1:0]  RESP_SLVERR              = 2'b10;
	localparam int          NUM_INPUTS               = 4;
endpackage

// file: hdl/clkin_monitor.sv
// Activity monitor, pre-divider and lock edge selection for one clock input
`timescale 1ns/1ps
module clkin_monitor
	import clkin_pkg::*;
#(
	parameter int TIMEOUT = EDGE_TIMEOUT
) (
	input  wire logic       aclk,
	input  wire logic       aresetn,
	input  wire logic       clk_in,
	input  wire logic       mon_disable,
	input  wire logic [2:0] valwin,
	input  wire logic [1:0] prediv,
	input  wire logic       lock_edge,
	output logic            valid,
	output logic            pll_ref
);
	logic              sync1_q;
	logic              sync2_q;
	logic              last_q;
	logic              edge_w;
	logic [TMO_W-1:0]  idle_q;
	logic [WIN_W-1:0]  good_q;
	logic [WIN_W-1:0]  need_w;
	logic [2:0]        div_q;
	logic              ref_w;

	// Window length from the validation code; reserved codes fall back to the longest window
	function automatic logic [WIN_W-1:0] win_len(input logic [2:0] code);
		case (code)
			3'h0:    win_len = 11'h001;
			3'h1:    win_len = 11'h004;
			3'h2:    win_len = 11'h010;
			3'h3:    win_len = 11'h040;
			3'h4:    win_len = 11'h100;
			default: win_len = 11'h400;
		endcase
	endfunction

	// Two-stage synchroniser; the first stage feeds only the second
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_q <= 1'b0;
			sync2_q <= 1'b0;
			last_q  <= 1'b0;
		end else begin
			sync1_q <= clk_in;
			sync2_q <= sync1_q;
			last_q  <= sync2_q;
		end
	end

	// Monitor sees edges only while its feed is enabled
	assign edge_w = !mon_disable && (sync2_q != last_q) && sync2_q;
	assign need_w = win_len(valwin);

	// Missing-edge detection and run-length count of good cycles
	always_ff @(posedge aclk) begin
		if (!aresetn || mon_disable) begin
			idle_q <= '0;
			good_q <= '0;
		end else if (edge_w) begin
			idle_q <= '0;
			if (good_q < need_w) begin // Saturate: a shorter window must not let the count wrap
				good_q <= good_q + 11'h001;
			end
		end else if (idle_q == TMO_W'(TIMEOUT - 1)) begin
			idle_q <= '0; // Edge missing: restart the window
			good_q <= '0;
		end else begin
			idle_q <= idle_q + 7'h01;
		end
	end

	// Valid only after a whole window without a missing edge
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			valid <= 1'b0;
		end else begin
			valid <= (good_q >= need_w) && !mon_disable;
		end
	end

	// Pre-divider counts selected edges of the synchronised input
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_q <= '0;
		end else if ((sync2_q != last_q) && (sync2_q != lock_edge)) begin
			div_q <= div_q + 3'h1;
		end
	end

	// Falling edge lock inverts the undivided reference seen by the PLL; with a pre-divider it counts falling edges instead
	always_comb begin
		case (prediv)
			2'h0:    ref_w = sync2_q ^ lock_edge;
			2'h1:    ref_w = div_q[0];
			2'h2:    ref_w = div_q[1];
			default: ref_w = div_q[2];
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_ref <= 1'b0;
		end else begin
			pll_ref <= ref_w;
		end
	end
endmodule

// file: hdl/clkin_config.sv
// Input clock front end: AXI4-Lite register file and four input monitors
//
// Overview of operation
// - A zero feed-disable bit on the crystal input routes that input to its monitor, a one blocks it.
// - The crystal monitor reports valid only after a full window with no missing edge.
// - Window codes 0..5 give 1, 4, 16, 64, 256 and 1024 cycles; codes 6 and 7 are unused.
// - Crystal pre-divider code 00 divides by one and 01 by two; 10 and 11 are unused.
// - On each clock input the lock-edge bit picks rising (0) or falling (1) edge for the PLL.
// - On each clock input a zero feed-disable bit feeds its monitor, a one withholds it.
// - Each clock-input monitor reports valid only after its own full window without a missing edge.
// - Clock input pre-divider codes 00..11 divide by 1, 2, 4 and 8.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module clkin_config
	import clkin_pkg::*;
#(
	parameter int TIMEOUT = EDGE_TIMEOUT
) (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	input  wire logic [NUM_INPUTS-1:0] clk_in,
	output logic [NUM_INPUTS-1:0]      input_valid,
	output logic [NUM_INPUTS-1:0]      pll_ref,
	output logic [7:0]                 xtal_amp_level,
	output logic [7:0]                 xtal_cap_sel
);
	import clkin_pkg::*;

	logic [7:0]            cfg_q [NUM_INPUTS];
	logic [7:0]            amp_q;
	logic [7:0]            caps_q;
	logic                  doubler_q;
	logic [ADDR_W-1:0]     awaddr_q;
	logic                  aw_held_q;
	logic [31:0]           wdata_q;
	logic                  w_held_q;
	logic                  wstrb0_q;
	logic                  do_write;
	logic                  wr_hit;
	logic [31:0]           rdata_d;
	logic                  rd_hit;
	logic [NUM_INPUTS-1:0] valid_w;
	logic [1:0]            xtal_div_w;

	// Register index from a byte address; unaligned bits are ignored
	function automatic logic [11:0] reg_index(input logic [ADDR_W-1:0] addr);
		reg_index = addr[ADDR_W-1:2];
	endfunction

	// Index to input slot: 0 is the crystal, 1..3 the clock inputs
	function automatic logic [2:0] cfg_slot(input logic [11:0] idx);
		case (idx)
			IDX_XTAL_INPUT_CONFIG: cfg_slot = 3'h0;
			IDX_CLOCK_INPUT_ONE:   cfg_slot = 3'h1;
			IDX_CLOCK_INPUT_TWO:   cfg_slot = 3'h2;
			IDX_CLOCK_INPUT_THREE: cfg_slot = 3'h3;
			default:               cfg_slot = 3'h4;
		endcase
	endfunction

	// Address and data are taken in either order and held until both are present
	assign s_axi_awready = !aw_held_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_held_q && !s_axi_bvalid;
	assign do_write      = aw_held_q && w_held_q && !s_axi_bvalid;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_q <= 1'b0;
			awaddr_q  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_q <= 1'b1;
			awaddr_q  <= s_axi_awaddr;
		end else if (do_write) begin
			aw_held_q <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb0_q <= 1'b0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata;
			wstrb0_q <= s_axi_wstrb[0];
		end else if (do_write) begin
			w_held_q <= 1'b0;
		end
	end

	// Decode of the held write address
	always_comb begin
		case (reg_index(awaddr_q))
			IDX_XTAL_INPUT_CONFIG, IDX_XTAL_AMP_CONTROL, IDX_XTAL_LOAD_CAPS,
			IDX_CLOCK_INPUT_ONE, IDX_CLOCK_INPUT_TWO, IDX_CLOCK_INPUT_THREE,
			IDX_MASTER_CONFIG_TWO: wr_hit = 1'b1;
			default:               wr_hit = 1'b0;
		endcase
	end

	// Input configuration bytes; bit 7 is reserved and reads zero
	generate
		for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_cfg
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					cfg_q[i] <= RST_CONFIG;
				end else if (do_write && wstrb0_q && cfg_slot(reg_index(awaddr_q)) == 3'(i)) begin
					cfg_q[i] <= {1'b0, wdata_q[6:0]};
				end
			end
		end
	endgenerate

	// Amplitude and load cap settings are stored and passed to the crystal driver; the doubler bit is only stored for readback
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			amp_q     <= RST_CONFIG;
			caps_q    <= RST_CONFIG;
			doubler_q <= 1'b0;
		end else if (do_write && wstrb0_q) begin
			if (reg_index(awaddr_q) == IDX_XTAL_AMP_CONTROL) begin
				amp_q <= wdata_q[7:0];
			end
			if (reg_index(awaddr_q) == IDX_XTAL_LOAD_CAPS) begin
				caps_q <= wdata_q[7:0];
			end
			if (reg_index(awaddr_q) == IDX_MASTER_CONFIG_TWO) begin
				doubler_q <= wdata_q[DOUBLER_BIT];
			end
		end
	end

	// Write response one cycle after both halves are in; unmapped gets SLVERR
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// Read mux; status word shows each monitor's valid flag
	always_comb begin
		rdata_d = '0;
		rd_hit  = 1'b1;
		case (reg_index(s_axi_araddr))
			IDX_XTAL_INPUT_CONFIG: rdata_d[7:0] = cfg_q[0];
			IDX_XTAL_AMP_CONTROL:  rdata_d[7:0] = amp_q;
			IDX_XTAL_LOAD_CAPS:    rdata_d[7:0] = caps_q;
			IDX_CLOCK_INPUT_ONE:   rdata_d[7:0] = cfg_q[1];
			IDX_CLOCK_INPUT_TWO:   rdata_d[7:0] = cfg_q[2];
			IDX_CLOCK_INPUT_THREE: rdata_d[7:0] = cfg_q[3];
			IDX_MASTER_CONFIG_TWO: rdata_d[DOUBLER_BIT] = doubler_q;
			IDX_MONITOR_STATUS:    rdata_d[NUM_INPUTS-1:0] = valid_w;
			default:               rd_hit = 1'b0;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	// Read data registered; held until the master takes it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rdata_d;
			s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Crystal only divides by 1 or 2; reserved codes act as divide by 2
	// Doubler with divide-by-two is left to software, no interlock
	assign xtal_div_w = {1'b0, cfg_q[0][PREDIV_LSB+1] | cfg_q[0][PREDIV_LSB]};

	// One monitor per input; slot 0 is the crystal input pin
	generate
		for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_mon
			clkin_monitor #(
				.TIMEOUT     (TIMEOUT)
			) u_mon (
				.aclk        (aclk),
				.aresetn     (aresetn),
				.clk_in      (clk_in[i]),
				.mon_disable (cfg_q[i][MON_DIS_BIT]),
				.valwin      (cfg_q[i][VALWIN_LSB+2:VALWIN_LSB]),
				.prediv      ((i == 0) ? xtal_div_w : cfg_q[i][PREDIV_LSB+1:PREDIV_LSB]),
				.lock_edge   (cfg_q[i][LOCK_EDGE_BIT]),
				.valid       (valid_w[i]),
				.pll_ref     (pll_ref[i])
			);
		end
	endgenerate

	assign input_valid    = valid_w;
	assign xtal_amp_level = amp_q;
	assign xtal_cap_sel   = caps_q;
endmodule

// file: tb/clk_src_model.sv
// Reference clock sources feeding the four inputs
`timescale 1ns/1ps
module clk_src_model #(
	parameter real HALF_NS [4] = '{113.3, 131.7, 157.1, 173.9}
) (
	input  wire logic [3:0] run,
	output logic [3:0]      clk_in
);
	for (genvar k = 0; k < 4; k++) begin : g_src
		// A stopped source parks low, so the monitor sees edges go missing
		always begin
			if (run[k]) begin
				#(HALF_NS[k]);
				clk_in[k] = ~clk_in[k];
			end else begin
				clk_in[k] = 1'b0;
				@(posedge run[k]);
			end
		end
	end
endmodule

// file: tb/clkin_config_checker.sv
// Bus and monitor checks on the ports of the input clock block
`timescale 1ns/1ps
module clkin_config_checker
	import clkin_pkg::*;
#(
	parameter int TIMEOUT = EDGE_TIMEOUT
) (
	input wire logic                  aclk,
	input wire logic                  aresetn,
	input wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input wire logic                  s_axi_awvalid,
	input wire logic                  s_axi_awready,
	input wire logic [31:0]           s_axi_wdata,
	input wire logic [3:0]            s_axi_wstrb,
	input wire logic                  s_axi_wvalid,
	input wire logic                  s_axi_wready,
	input wire logic [1:0]            s_axi_bresp,
	input wire logic                  s_axi_bvalid,
	input wire logic                  s_axi_bready,
	input wire logic [ADDR_W-1:0]     s_axi_araddr,
	input wire logic                  s_axi_arvalid,
	input wire logic                  s_axi_arready,
	input wire logic [31:0]           s_axi_rdata,
	input wire logic [1:0]            s_axi_rresp,
	input wire logic                  s_axi_rvalid,
	input wire logic                  s_axi_rready,
	input wire logic [NUM_INPUTS-1:0] clk_in,
	input wire logic [NUM_INPUTS-1:0] input_valid,
	input wire logic [NUM_INPUTS-1:0] pll_ref,
	input wire logic [7:0]            xtal_amp_level,
	input wire logic [7:0]            xtal_cap_sel
);
	logic [ADDR_W-1:0] aw_q;
	logic [7:0]        wd_q;
	logic              ws_q;
	logic [3:0]        dis_q, dis_old_q, val_old_q, clk_old_q, early;
	logic [2:0]        win_q [4];
	logic [10:0]       cnt_q [4];
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	function automatic int win_len(input logic [2:0] c);
		return (c > 3'd5) ? 1024 : (1 << (2 * c));
	endfunction
	// Shadow fields lag the design by a cycle, hence the slack below
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dis_q <= 4'h0;
			win_q <= '{default: 3'h0};
		end else begin
			if (s_axi_awvalid && s_axi_awready) aw_q <= s_axi_awaddr;
			if (s_axi_wvalid && s_axi_wready) {ws_q, wd_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
			for (int k = 0; k < 4; k++) begin
				if (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY && ws_q
					&& aw_q == ADDR_W'({(k == 0) ? IDX_XTAL_INPUT_CONFIG : IDX_CLOCK_INPUT_ONE + 12'(k - 1), 2'b00})) begin
					dis_q[k] <= wd_q[MON_DIS_BIT];
					win_q[k] <= wd_q[VALWIN_LSB +: 3];
				end
			end
		end
	end
	// Raw edges seen while invalid; raw sampling runs ahead of the synchroniser
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q <= '{default: 11'h0};
			{dis_old_q, val_old_q, clk_old_q} <= 12'h0;
		end else begin
			{dis_old_q, val_old_q, clk_old_q} <= {dis_q, input_valid, clk_in};
			for (int k = 0; k < 4; k++) begin
				if (input_valid[k] || dis_q[k]) cnt_q[k] <= 11'h0;
				else if (clk_in[k] && !clk_old_q[k] && cnt_q[k] != 11'h7ff) cnt_q[k] <= cnt_q[k] + 11'h1;
			end
		end
	end
	// Valid rising before a full window of edges
	always_comb begin
		for (int k = 0; k < 4; k++) begin
			early[k] = input_valid[k] && !val_old_q[k] && (int'(cnt_q[k]) + 1 < win_len(win_q[k]));
		end
	end
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_rlat;
		s_ar_taken |=> s_axi_rvalid;
	endproperty
	property p_brefuse;
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
	endproperty
	property p_rupper;
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0 && !s_axi_arready;
	endproperty
	property p_feed_x;
		dis_q[0] && dis_old_q[0] |-> !input_valid[0];
	endproperty
	property p_feed_n;
		(dis_q[3:1] & dis_old_q[3:1] & input_valid[3:1]) == 3'h0;
	endproperty
	property p_win_x;
		!early[0];
	endproperty
	property p_win_n;
		early[3:1] == 3'h0;
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	a_rlat: assert property (p_rlat) else $error("read answer late");
	a_brefuse: assert property (p_brefuse) else $error("write taken while answering");
	a_rupper: assert property (p_rupper) else $error("bad read answer");
	a_feed_x: assert property (p_feed_x) else $error("crystal valid while withheld");
	a_feed_n: assert property (p_feed_n) else $error("input valid while withheld");
	a_win_x: assert property (p_win_x) else $error("crystal valid too soon");
	a_win_n: assert property (p_win_n) else $error("input valid too soon");
endmodule
bind clkin_config clkin_config_checker #(.TIMEOUT(TIMEOUT)) chk (.*);

// file: tb/clkin_config_tb_top.sv
// Self-checking bench for the input clock block
`timescale 1ns/1ps
module clkin_config_tb_top;
	import clkin_pkg::*;
	localparam int TMO = 32;
	localparam int LIMIT = 90000;
	logic              aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0]       s_axi_wdata, s_axi_rdata, rd;
	logic [3:0]        s_axi_wstrb, run, clk_in, input_valid, pll_ref;
	logic [1:0]        s_axi_bresp, s_axi_rresp, r;
	logic [7:0]        xtal_amp_level, xtal_cap_sel;
	int                errors = 0, n_checks = 0, cyc = 0;
	clkin_config #(.TIMEOUT(TMO)) dut (.*);
	clk_src_model src (.*);
	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Both halves offered together; each dropped once taken
	task automatic wr(input logic [11:0] idx, input logic [7:0] v, input logic [3:0] st);
		int t = 0;
		@(posedge aclk);
		{s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {idx, 2'b00, 24'h0, v, st};
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!(s_axi_bvalid && s_axi_bready) && t < 100);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
		check("write answered", 1, t < 100);
	endtask
	task automatic rdreg(input logic [11:0] idx);
		int t = 0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00};
		{s_axi_arvalid, s_axi_rready} <= 2'b11;
		do begin
			@(posedge aclk);
			t++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!(s_axi_rvalid && s_axi_rready) && t < 100);
		{rd, r} = {s_axi_rdata, s_axi_rresp};
		s_axi_rready <= 1'b0;
		check("read answered", 1, t < 100);
	endtask
	// Slot 0 is the crystal register, slots 1..3 the clock input registers
	function automatic logic [11:0] slot_idx(input int k);
		return (k == 0) ? IDX_XTAL_INPUT_CONFIG : IDX_CLOCK_INPUT_ONE + 12'(k - 1);
	endfunction
	// Withhold, then feed, and count edges until valid
	task automatic win_test(input int k, input logic [2:0] c);
		int w, e = 0, t = 0;
		logic p;
		w = (c > 3'd5) ? 1024 : (1 << (2 * c));
		wr(slot_idx(k), {3'b001, c, 2'b00}, 4'h1);
		repeat (4) @(posedge aclk);
		check("valid withheld", 0, input_valid[k]);
		wr(slot_idx(k), {3'b000, c, 2'b00}, 4'h1);
		p = clk_in[k];
		while (input_valid[k] !== 1'b1 && t < 20000) begin
			@(posedge aclk);
			t++;
			if (clk_in[k] && !p) e++;
			p = clk_in[k];
		end
		check("edges to valid", 1, e + 1 >= w && e <= w + 1);
	endtask
	// Reference rises per input rise, and input level at each reference rise
	task automatic div_test(input int k, input logic [1:0] dv, input logic edg, input int n);
		int ins = 0, prs = 0, bad = 0;
		logic pi, pp;
		wr(slot_idx(k), {1'b0, edg, 4'h0, dv}, 4'h1);
		repeat (60) @(posedge aclk);
		{pi, pp} = {clk_in[k], pll_ref[k]};
		repeat (1200) begin
			@(posedge aclk);
			if (clk_in[k] && !pi) ins++;
			if (pll_ref[k] && !pp) begin
				prs++;
				if (clk_in[k] !== !edg) bad++;
			end
			{pi, pp} = {clk_in[k], pll_ref[k]};
		end
		check("divide ratio", 1, prs * n + n >= ins && prs * n <= ins + n);
		check("lock edge", 0, bad);
	endtask
	// Ceiling on the whole run
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == LIMIT) begin
			errors++;
			tally_and_finish;
		end
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} <= 6'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} <= '0;
		run <= 4'hf;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			rdreg(12'h300 + 12'(i));
			check("reset value", 0, rd);
			check("read resp", RESP_OKAY, r);
		end
		rdreg(12'h308);
		check("unmapped resp", RESP_SLVERR, r);
		check("unmapped data", 0, rd);
		wr(12'h307, 8'h0f, 4'h1);
		check("status write resp", RESP_SLVERR, r);
		wr(12'h301, 8'ha5, 4'h1);
		wr(12'h302, 8'h5a, 4'h1);
		check("amp out", 8'ha5, xtal_amp_level);
		check("cap out", 8'h5a, xtal_cap_sel);
		wr(12'h305, 8'hff, 4'h1);
		wr(12'h305, 8'h00, 4'h0);
		rdreg(12'h305);
		check("config readback", 32'h7f, rd);
		wr(IDX_MASTER_CONFIG_TWO, 8'h01, 4'h1);
		rdreg(IDX_MASTER_CONFIG_TWO);
		check("doubler readback", 32'h1, rd);
		wr(IDX_MASTER_CONFIG_TWO, 8'h00, 4'h1);
		for (int c = 0; c < 8; c++) win_test(c % 4, 3'(c));
		rdreg(IDX_MONITOR_STATUS);
		check("status all valid", 32'hf, rd);
		run <= 4'hb;
		repeat (TMO + 40) @(posedge aclk);
		check("valid after stop", 0, input_valid[2]);
		rdreg(IDX_MONITOR_STATUS);
		check("status after stop", 32'hb, rd);
		run <= 4'hf;
		for (int v = 0; v < 4; v++) begin
			div_test(0, 2'(v), v[0], (v == 0) ? 1 : 2);
			div_test(1 + v % 3, 2'(v), !v[0], 1 << v);
		end
		tally_and_finish;
	end
endmodule
